// ### pkg/epgpio_pkg.sv
// Constants for the eight-pin port with edge detection.
// Assumes a register decoder that hands 16-bit words and word addresses to the port.
// What this block does
// - Bits 15:8 of the control register enable pins 0 to 7, one bit per pin, 1 meaning enabled.
// - Bits 7:0 of the control register set each pin's direction, 0 input and 1 output.
// - An enabled output pin drives its bit from the writable upper byte of the data register.
// - The low byte of the data register reads back the sampled input levels and ignores writes.
// - Rising edges are recorded only for pins whose bit is set in bits 15:8 of edge control.
// - Falling edges are recorded only for pins whose bit is set in bits 7:0 of edge control.
// - A status flag sets on an enabled edge of its kind at an enabled input pin and stays set until it is read.
package epgpio_pkg;
  localparam int PINS = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Word addresses
  localparam logic [7:0] ADDR_PIN_CTRL = 8'h0B;
  localparam logic [7:0] ADDR_PIN_DATA = 8'h0C;
  localparam logic [7:0] ADDR_EDGE_CTRL = 8'h0D;
  localparam logic [7:0] ADDR_EDGE_FLAG = 8'h0E;

  // Field positions: each field is one byte wide
  localparam int ENABLE_LSB = 8;
  localparam int DIR_LSB = 0;
  localparam int DRIVE_LSB = 8;
  localparam int SAMPLED_LSB = 0;
  localparam int RISE_LSB = 8;
  localparam int FALL_LSB = 0;

  // Reset values
  localparam logic [7:0] PIN_CTRL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] READ_NONE = 16'h0000;
endpackage

// ### pkg/epgpio_pin_if.sv
// Carries the filtered pin levels and edge pulses from the synchroniser to the core.
// Assumes one clock for both ends.
`timescale 1ns/1ns
`default_nettype none
interface epgpio_pin_if;
  logic [7:0] level;
  logic [7:0] rise;
  logic [7:0] fall;
  modport sync (output level, output rise, output fall);
  modport core (input level, input rise, input fall);
endinterface
`default_nettype wire

// ### hw/epgpio_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes pins are asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module epgpio_sync
  import epgpio_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Raw pins
  input wire logic [PINS-1:0] pinIn,
  // Filtered result
  epgpio_pin_if.sync pins
);
  logic [PINS-1:0] meta;
  logic [PINS-1:0] syncA;
  logic [PINS-1:0] syncB;
  logic [PINS-1:0] level;
  wire [PINS-1:0] agree = ~(syncA ^ syncB);
  wire [PINS-1:0] changed = agree & (syncB ^ level);

  // The first stage feeds only the second
  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= BYTE_RESET;
      syncA <= BYTE_RESET;
      syncB <= BYTE_RESET;
    end else if (ce) begin
      meta <= pinIn;
      syncA <= meta;
      syncB <= syncA;
    end
  end

  genvar i;
  generate
    for (i = 0; i < PINS; i++) begin : gLevel
      always_ff @(posedge clk) begin
        if (srst) begin
          level[i] <= 1'b0;
        end else if (ce && changed[i]) begin
          level[i] <= syncB[i];
        end
      end
      assign pins.rise[i] = ce & changed[i] & syncB[i];
      assign pins.fall[i] = ce & changed[i] & ~syncB[i];
    end
  endgenerate

  assign pins.level = level;
endmodule // epgpio_sync
`default_nettype wire

// ### hw/epgpio_top.sv
// Eight general-purpose pins with direction, output data, sampled input and edge flags.
// Assumes the serial decoder gives one-cycle read and write strobes with a word address.
`timescale 1ns/1ns
`default_nettype none
module epgpio_top
  import epgpio_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Register port from the serial decoder
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic regWrite,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdata,
  output logic regRdataValid,
  // Pins
  input wire logic [PINS-1:0] pinIn,
  output logic [PINS-1:0] pinOut,
  output logic [PINS-1:0] pinOe
);
  logic [PINS-1:0] pinEnable;
  logic [PINS-1:0] pinDirection;
  logic [PINS-1:0] pinDriveValue;
  logic [PINS-1:0] pinSampledValue;
  logic [PINS-1:0] riseDetectEnable;
  logic [PINS-1:0] fallDetectEnable;
  logic [PINS-1:0] riseSeenFlag;
  logic [PINS-1:0] fallSeenFlag;
  logic [PINS-1:0] next_riseSeenFlag;
  logic [PINS-1:0] next_fallSeenFlag;
  logic [DATA_W-1:0] next_regRdata;

  epgpio_pin_if pinBus ();

  epgpio_sync uSync (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .pinIn(pinIn),
    .pins(pinBus.sync)
  );

  // Address decode
  wire selCtrl = (regAddr == ADDR_PIN_CTRL);
  wire selData = (regAddr == ADDR_PIN_DATA);
  wire selEdgeCtrl = (regAddr == ADDR_EDGE_CTRL);
  wire selEdgeFlag = (regAddr == ADDR_EDGE_FLAG);
  wire wrCtrl = regWrite & selCtrl;
  wire wrData = regWrite & selData;
  wire wrEdgeCtrl = regWrite & selEdgeCtrl;
  wire flagReadClear = regRead & selEdgeFlag;

  // Per-pin qualifiers
  wire [PINS-1:0] activeInput = pinEnable & ~pinDirection;
  wire [PINS-1:0] riseEvent = pinBus.rise & activeInput & riseDetectEnable;
  wire [PINS-1:0] fallEvent = pinBus.fall & activeInput & fallDetectEnable;

  // Sticky flags: a new edge wins over the clearing read
  assign next_riseSeenFlag = (flagReadClear ? BYTE_RESET : riseSeenFlag) | riseEvent;
  assign next_fallSeenFlag = (flagReadClear ? BYTE_RESET : fallSeenFlag) | fallEvent;

  // Read data mux; unmapped addresses read zero
  wire [DATA_W-1:0] ctrlWord = {pinEnable, pinDirection};
  wire [DATA_W-1:0] dataWord = {pinDriveValue, pinSampledValue};
  wire [DATA_W-1:0] edgeCtrlWord = {riseDetectEnable, fallDetectEnable};
  wire [DATA_W-1:0] flagWord = {riseSeenFlag, fallSeenFlag};
  assign next_regRdata = selCtrl ? ctrlWord :
                         selData ? dataWord :
                         selEdgeCtrl ? edgeCtrlWord :
                         selEdgeFlag ? flagWord : READ_NONE;

  // Control register
  always_ff @(posedge clk) begin
    if (srst) begin
      pinEnable <= PIN_CTRL_RESET;
      pinDirection <= PIN_CTRL_RESET;
    end else if (ce && wrCtrl) begin
      pinEnable <= regWdata[ENABLE_LSB +: PINS];
      pinDirection <= regWdata[DIR_LSB +: PINS];
    end
  end

  // Output data byte; the input byte is not writable
  always_ff @(posedge clk) begin
    if (srst) begin
      pinDriveValue <= BYTE_RESET;
    end else if (ce && wrData) begin
      pinDriveValue <= regWdata[DRIVE_LSB +: PINS];
    end
  end

  // Edge control register
  always_ff @(posedge clk) begin
    if (srst) begin
      riseDetectEnable <= BYTE_RESET;
      fallDetectEnable <= BYTE_RESET;
    end else if (ce && wrEdgeCtrl) begin
      riseDetectEnable <= regWdata[RISE_LSB +: PINS];
      fallDetectEnable <= regWdata[FALL_LSB +: PINS];
    end
  end

  // Sampled input: only enabled input pins follow their pin
  genvar i;
  generate
    for (i = 0; i < PINS; i++) begin : gSample
      always_ff @(posedge clk) begin
        if (srst) begin
          pinSampledValue[i] <= 1'b0;
        end else if (ce && activeInput[i]) begin
          pinSampledValue[i] <= pinBus.level[i];
        end
      end
    end
  endgenerate

  // Edge flags
  always_ff @(posedge clk) begin
    if (srst) begin
      riseSeenFlag <= BYTE_RESET;
      fallSeenFlag <= BYTE_RESET;
    end else if (ce) begin
      riseSeenFlag <= next_riseSeenFlag;
      fallSeenFlag <= next_fallSeenFlag;
    end
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      regRdata <= READ_NONE;
      regRdataValid <= 1'b0;
    end else if (ce) begin
      regRdataValid <= regRead;
      if (regRead) begin
        regRdata <= next_regRdata;
      end
    end
  end

  // Register values as they stand after this edge
  wire [PINS-1:0] next_pinEnable = wrCtrl ? regWdata[ENABLE_LSB +: PINS] : pinEnable;
  wire [PINS-1:0] next_pinDirection = wrCtrl ? regWdata[DIR_LSB +: PINS] : pinDirection;
  wire [PINS-1:0] next_pinDriveValue = wrData ? regWdata[DRIVE_LSB +: PINS] : pinDriveValue;

  // Pin drive from flip-flops, updated at the same edge as the registers behind it
  always_ff @(posedge clk) begin
    if (srst) begin
      pinOut <= BYTE_RESET;
      pinOe <= BYTE_RESET;
    end else if (ce) begin
      pinOut <= next_pinDriveValue & next_pinEnable & next_pinDirection;
      pinOe <= next_pinEnable & next_pinDirection;
    end
  end
endmodule // epgpio_top
`default_nettype wire

// ### tb/epgpio_far_end.sv
// Far-side circuitry: driven pins loop back, other pins take bench levels.
// Assumes the bench sets the levels of pins that the port does not drive.
`timescale 1ns/1ns
`default_nettype none
module epgpio_far_end (
  // Pins
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] extLevel,
  output logic [7:0] pinIn
);
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule // epgpio_far_end
`default_nettype wire

// ### tb/epgpio_asserts.sv
// Port checker; shadows the writable registers from the write strobes.
// Assumes it is bound into the port and sees only the port's own pins.
`timescale 1ns/1ns
`default_nettype none
module epgpio_asserts
  import epgpio_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic regWrite,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regRead,
  input wire logic [DATA_W-1:0] regRdata,
  input wire logic regRdataValid,
  input wire logic [PINS-1:0] pinIn,
  input wire logic [PINS-1:0] pinOut,
  input wire logic [PINS-1:0] pinOe
);
  logic [15:0] ctrl, edg;
  logic [7:0] drv;
  logic rdOk;
  assign rdOk = regRead && ce;
  always_ff @(posedge clk) begin
    if (srst) begin
      {ctrl, edg, drv} <= 40'h0;
    end else if (regWrite && ce) begin
      if (regAddr == ADDR_PIN_CTRL) ctrl <= regWdata;
      if (regAddr == ADDR_EDGE_CTRL) edg <= regWdata;
      if (regAddr == ADDR_PIN_DATA) drv <= regWdata[15:8];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_oe_map: assert property (pinOe == (ctrl[15:8] & ctrl[7:0])) else $error("oe");
  a_out_map: assert property (pinOut == (drv & pinOe)) else $error("out");
  a_rd_valid: assert property (rdOk |=> regRdataValid) else $error("valid");
  a_no_valid: assert property (ce && !regRead |=> !regRdataValid) else $error("idle");
  a_rd_hold: assert property (!regRdataValid |-> $stable(regRdata)) else $error("hold");
  a_ctrl_back: assert property (
    rdOk && regAddr == ADDR_PIN_CTRL |=> regRdata == $past(ctrl)) else $error("ctrl");
  a_edge_back: assert property (
    rdOk && regAddr == ADDR_EDGE_CTRL |=> regRdata == $past(edg)) else $error("edge");
  a_drv_back: assert property (
    rdOk && regAddr == ADDR_PIN_DATA |=> regRdata[15:8] == $past(drv)) else $error("drive");
  cover property (rdOk && regAddr == ADDR_EDGE_FLAG);
  cover property (regRdataValid && regRdata != 16'h0000);
  cover property (pinOe != 8'h00);
endmodule // epgpio_asserts
bind epgpio_top epgpio_asserts u_epgpio_asserts (.*);
`default_nettype wire

// ### tb/test_epgpio_top.sv
// Random register and pin traffic compared with a bench model of the port.
// Assumes the far-side model loops driven pins back and lets the bench set the rest.
`timescale 1ns/1ns
`default_nettype none
module test_epgpio_top
  import epgpio_pkg::*;
;
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic [7:0] regAddr = 8'h00, ext = 8'h00, pinIn, pinOut, pinOe;
  logic [15:0] regWdata = 16'h0000, regRdata;
  logic regRdataValid;
  int error_cnt = 0, check_count = 0, ctrl = 0, edg = 0, drv = 0, smp = 0, flg = 0, lvl = 0;
  int expq[$];
  always #25 clk = ~clk;
  epgpio_top u_epgpio_top (.clk(clk), .srst(srst), .ce(ce), .regAddr(regAddr),
    .regWrite(regWrite), .regWdata(regWdata), .regRead(regRead), .regRdata(regRdata),
    .regRdataValid(regRdataValid), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
  epgpio_far_end u_epgpio_far_end (.pinOut(pinOut), .pinOe(pinOe), .extLevel(ext),
    .pinIn(pinIn));
  task automatic tally(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_read(input logic [15:0] got, input logic [15:0] exp);
    tally(got, exp);
  endtask
  task automatic check_valid(input logic got);
    tally({15'h0000, got}, 16'h0001);
  endtask
  task automatic check_pins(input logic [7:0] oe, input logic [7:0] out, input logic [15:0] exp);
    tally({oe, out}, exp);
  endtask
  // A write attempted while the clock enable is low must leave everything as it was
  task automatic frozen_wr(input logic [15:0] d);
    @(negedge clk);
    ce = 1'b0;
    regAddr = ADDR_PIN_CTRL;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
    ce = 1'b1;
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
    if (a == ADDR_PIN_CTRL) ctrl = d;
    if (a == ADDR_EDGE_CTRL) edg = d;
    if (a == ADDR_PIN_DATA) drv = d[15:8];
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk);
    regRead = 1'b0;
    expq.push_back(a == ADDR_PIN_CTRL ? ctrl : a == ADDR_EDGE_CTRL ? edg :
      a == ADDR_PIN_DATA ? drv << 8 | smp : a == ADDR_EDGE_FLAG ? flg : 0);
    if (a == ADDR_EDGE_FLAG) flg = 0;
    check_valid(regRdataValid);
    check_read(regRdata, 16'(expq.pop_front()));
  endtask
  task automatic settle();
    int m, oe, nl;
    repeat (6) @(negedge clk);
    m = ctrl >> 8 & ~ctrl & 255;
    oe = ctrl >> 8 & ctrl & 255;
    nl = (oe & drv | ~oe & ext) & 255;
    flg |= (m & edg >> 8 & nl & ~lvl) << 8 | m & edg & ~nl & lvl;
    smp = smp & ~m | nl & m;
    lvl = nl;
    check_pins(pinOe, pinOut, 16'(oe << 8 | drv & oe));
  endtask
  initial begin
    void'($urandom(9738));
    repeat (3) @(negedge clk);
    srst = 1'b0;
    for (int i = 0; i < 300; i++) begin
      case ($urandom_range(4))
        0: wr(ADDR_PIN_CTRL, 16'($urandom));
        1: wr(ADDR_EDGE_CTRL, 16'($urandom));
        2: wr(8'($urandom_range(15, 12)), 16'($urandom));
        3: frozen_wr(16'($urandom));
        default: ext = 8'($urandom);
      endcase
      settle();
      rd(8'($urandom_range(16, 10)));
      rd(ADDR_EDGE_FLAG);
    end
    $display("Random traffic test done");
    final_report();
  end
  initial begin
    #1000000;
    error_cnt++;
    final_report();
  end
endmodule // test_epgpio_top
`default_nettype wire
